/* File: hdl/pif_regs.vh */
// register map and field constants for the peripheral interrupt
// flag and enable block.
// assumes a 32-bit avalon-mm slave with byte addressing; each
// register index sits at byte address index*4, data in bits 7:0.
`ifndef PIF_REGS_VH
`define PIF_REGS_VH

// ----------------------------------------------------------------
// register indices (byte address is index times four)
// ----------------------------------------------------------------
`define PIF_IDX_EN0      12'hec2
`define PIF_IDX_EN1      12'hec3
`define PIF_IDX_EN2      12'hec4
`define PIF_IDX_EN3      12'hec5
`define PIF_IDX_EN4      12'hec6
`define PIF_IDX_EN5      12'hec7
`define PIF_IDX_EN6      12'hec8
`define PIF_IDX_EN7      12'hec9
`define PIF_IDX_FL4      12'hece
`define PIF_IDX_FL5      12'hecf
`define PIF_IDX_FL6      12'hed0
`define PIF_IDX_FL7      12'hed1
`define PIF_IDX_PRI0     12'heba
`define PIF_IDX_GCTL     12'hef2

// ----------------------------------------------------------------
// implemented-bit masks, packed one byte per register
// ----------------------------------------------------------------
// enables 7..0, byte 0 is irq_enable_0
`define PIF_EN_MASKS     64'he1_03_07_3f_ff_c3_c3_37
// flags 7..4, byte 0 is timer_event_flags
`define PIF_FL_MASKS     32'he1_03_07_3f

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define PIF_EN_RST       8'h00
`define PIF_FL_RST       8'h00
`define PIF_PRI0_RST     8'h31
`define PIF_GCTL_RST     8'h00

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define PIF_GCTL_PEN     0
`define PIF_GRP0_MASK    8'h37

// ----------------------------------------------------------------
// capture/compare mode codes
// ----------------------------------------------------------------
`define PIF_CC_CAPTURE   2'h0
`define PIF_CC_COMPARE   2'h1
`define PIF_CC_PWM       2'h2

`endif

/* File: hdl/pif_top.v */
// peripheral interrupt flag and enable registers with request
// gating towards the cpu interrupt logic.
// assumes all event inputs come from logic on clk_i, one-cycle
// pulses or levels; software reaches registers over avalon-mm.
// one clock domain, async active-high reset.
`include "pif_regs.vh"
`default_nettype none

// Function
// - timer4/timer2 match flags set, held until cleared
// - timer3/timer1 overflow flags set, held until cleared
// - timer5/3/1 gate flags set, held until cleared
// - capture events set capcomp flags in capture mode
// - compare match sets flag; pwm mode ignores it
// - scan, crc, nvm, waveform flags set on event
// - first enable register: timer0, pin change, external
// - global enable does not mask first group
// - enables for osc fail, switch, converter events
// - enables for voltage, zero cross, comparators
// - memory/crc/wave flags reset zero, read/write
// - priority bit one means high level
module pif_top (
    input  wire        clk_i,                 // system clock, 20 mhz
    input  wire        rst_i,                 // async reset, high
    input  wire [13:0] avs_address_i,         // byte address
    input  wire        avs_read_i,            // read request
    input  wire        avs_write_i,           // write request
    input  wire [31:0] avs_writedata_i,       // write data
    input  wire [3:0]  avs_byteenable_i,      // byte lanes
    output wire [31:0] avs_readdata_o,        // read data
    output wire        avs_waitrequest_o,     // stall
    input  wire        timer1_overflow_i,     // timer1 wrapped
    input  wire        timer2_match_i,        // timer2 hit period
    input  wire        timer3_overflow_i,     // timer3 wrapped
    input  wire        timer4_match_i,        // timer4 hit period
    input  wire        timer5_overflow_i,     // timer5 wrapped
    input  wire        timer6_match_i,        // timer6 hit period
    input  wire        timer1_gate_i,         // timer1 gate event
    input  wire        timer3_gate_i,         // timer3 gate event
    input  wire        timer5_gate_i,         // timer5 gate event
    input  wire        capcomp1_capture_i,    // unit1 captured
    input  wire        capcomp1_match_i,      // unit1 compare hit
    input  wire [1:0]  capcomp1_mode_i,       // unit1 mode code
    input  wire        capcomp2_capture_i,    // unit2 captured
    input  wire        capcomp2_match_i,      // unit2 compare hit
    input  wire [1:0]  capcomp2_mode_i,       // unit2 mode code
    input  wire        memory_scan_event_i,   // scan finished
    input  wire        checksum_event_i,      // crc finished
    input  wire        nonvolatile_event_i,   // nvm operation done
    input  wire        waveform_gen_event_i,  // waveform gen event
    input  wire [7:0]  first_request_group_i, // first group flags
    input  wire [7:0]  group1_flags_i,        // osc/converter flags
    input  wire [7:0]  group2_flags_i,        // voltage/comp flags
    input  wire [7:0]  group3_flags_i,        // serial port flags
    output wire        irq_high_o,            // high priority req
    output wire        irq_low_o,             // low priority req
    output wire        irq_periph_o           // gated periph req
);

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    reg  [31:0] flag_r;        // flags 4..7, one byte each
    reg  [63:0] en_r;          // enables 0..7, one byte each
    reg  [7:0]  pri0_r;        // first group priority bits
    reg  [7:0]  gctl_r;        // global control
    reg  [31:0] rdata_r;       // captured read data
    reg         rd_ack_r;      // read answer cycle
    reg         irq_high_r;    // registered high request
    reg         irq_low_r;     // registered low request
    reg         irq_periph_r;  // registered periph request

    // ------------------------------------------------------------
    // decode results
    // ------------------------------------------------------------
    reg  [7:0]  en_wr;         // enable byte write strobes
    reg  [3:0]  fl_wr;         // flag byte write strobes
    reg         pri0_wr;       // priority write strobe
    reg         gctl_wr;       // control write strobe
    reg  [7:0]  rd_nxt;        // selected read byte

    wire [31:0] set_vec;       // hardware set requests
    wire        wr_ok;         // write with low lane enabled
    wire        cc1_set;       // unit1 event in valid mode
    wire        cc2_set;       // unit2 event in valid mode
    wire [7:0]  grp0_act;      // first group active sources
    wire        periph_act;    // any gated periph source
    wire        irq_high_nxt;  // next high request
    wire        irq_low_nxt;   // next low request
    wire        irq_periph_nxt;// next periph request

    // masks as localparams: a macro literal
    // cannot be part-selected in a loop
    localparam [63:0] en_masks = `PIF_EN_MASKS; // enable masks
    localparam [31:0] fl_masks = `PIF_FL_MASKS; // flag masks

    // only lane 0 carries register data; upper lanes are ignored
    assign wr_ok = avs_write_i & avs_byteenable_i[0];

    // ------------------------------------------------------------
    // address decode and read mux
    // ------------------------------------------------------------
    // unmapped reads return zero, unmapped writes are dropped
    always @* begin
        // defaults: no strobe, read zero
        en_wr   = 8'h00;
        fl_wr   = 4'h0;
        pri0_wr = 1'b0;
        gctl_wr = 1'b0;
        rd_nxt  = 8'h00;

        if (avs_address_i == {`PIF_IDX_EN0, 2'b00}) begin
            // timer0, pin change, external
            en_wr[0] = wr_ok;
            rd_nxt   = en_r[7:0];
        end else if (avs_address_i == {`PIF_IDX_EN1, 2'b00}) begin
            // oscillator and converter
            en_wr[1] = wr_ok;
            rd_nxt   = en_r[15:8];
        end else if (avs_address_i == {`PIF_IDX_EN2, 2'b00}) begin
            // voltage, zero cross, comparators
            en_wr[2] = wr_ok;
            rd_nxt   = en_r[23:16];
        end else if (avs_address_i == {`PIF_IDX_EN3, 2'b00}) begin
            // serial port enables
            en_wr[3] = wr_ok;
            rd_nxt   = en_r[31:24];
        end else if (avs_address_i == {`PIF_IDX_EN4, 2'b00}) begin
            // timer match and overflow
            en_wr[4] = wr_ok;
            rd_nxt   = en_r[39:32];
        end else if (avs_address_i == {`PIF_IDX_EN5, 2'b00}) begin
            // timer gate enables
            en_wr[5] = wr_ok;
            rd_nxt   = en_r[47:40];
        end else if (avs_address_i == {`PIF_IDX_EN6, 2'b00}) begin
            // capture/compare enables
            en_wr[6] = wr_ok;
            rd_nxt   = en_r[55:48];
        end else if (avs_address_i == {`PIF_IDX_EN7, 2'b00}) begin
            // scan, crc, nvm, waveform
            en_wr[7] = wr_ok;
            rd_nxt   = en_r[63:56];
        end else if (avs_address_i == {`PIF_IDX_FL4, 2'b00}) begin
            // timer event flags
            fl_wr[0] = wr_ok;
            rd_nxt   = flag_r[7:0];
        end else if (avs_address_i == {`PIF_IDX_FL5, 2'b00}) begin
            // timer gate flags
            fl_wr[1] = wr_ok;
            rd_nxt   = flag_r[15:8];
        end else if (avs_address_i == {`PIF_IDX_FL6, 2'b00}) begin
            // capture/compare flags
            fl_wr[2] = wr_ok;
            rd_nxt   = flag_r[23:16];
        end else if (avs_address_i == {`PIF_IDX_FL7, 2'b00}) begin
            // scan, crc, nvm, waveform flags
            fl_wr[3] = wr_ok;
            rd_nxt   = flag_r[31:24];
        end else if (avs_address_i == {`PIF_IDX_PRI0, 2'b00}) begin
            // first group priority
            pri0_wr  = wr_ok;
            rd_nxt   = pri0_r;
        end else if (avs_address_i == {`PIF_IDX_GCTL, 2'b00}) begin
            // global control
            gctl_wr  = wr_ok;
            rd_nxt   = gctl_r;
        end else begin
            rd_nxt   = 8'h00;                       // unmapped
        end
    end

    // ------------------------------------------------------------
    // bus handshake
    // ------------------------------------------------------------
    // reads take one wait cycle so read data come from flops;
    // writes complete with no wait state
    assign avs_waitrequest_o = avs_read_i & ~rd_ack_r;

    assign avs_readdata_o    = rdata_r;

    // read capture and answer flag
    always @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            rd_ack_r <= 1'b0;
            rdata_r  <= 32'h0000_0000;
        end else begin
            rd_ack_r <= avs_read_i & ~rd_ack_r;
            // load once, so data stand while answered
            if (avs_read_i & ~rd_ack_r) begin
                rdata_r <= {24'h00_0000, rd_nxt};
            end
        end
    end

    // ------------------------------------------------------------
    // hardware set sources
    // ------------------------------------------------------------
    // capture counts only in capture mode, match only in compare;
    // pwm mode and the spare code never touch the flag
    assign cc1_set = (capcomp1_capture_i & (capcomp1_mode_i == `PIF_CC_CAPTURE)) |
                     (capcomp1_match_i & (capcomp1_mode_i == `PIF_CC_COMPARE));

    assign cc2_set = (capcomp2_capture_i & (capcomp2_mode_i == `PIF_CC_CAPTURE)) |
                     (capcomp2_match_i & (capcomp2_mode_i == `PIF_CC_COMPARE));

    // packed in register order, flags 4 in the low byte
    assign set_vec = {memory_scan_event_i,
                      checksum_event_i,
                      nonvolatile_event_i,
                      4'h0,
                      waveform_gen_event_i,
                      6'h00,
                      cc2_set,
                      cc1_set,
                      5'h00,
                      timer5_gate_i,
                      timer3_gate_i,
                      timer1_gate_i,
                      2'h0,
                      timer6_match_i,
                      timer5_overflow_i,
                      timer4_match_i,
                      timer3_overflow_i,
                      timer2_match_i,
                      timer1_overflow_i};

    // ------------------------------------------------------------
    // sticky flag bits
    // ------------------------------------------------------------
    // a set in the same cycle as a software clear wins, so an
    // event is never lost; unimplemented bits stay zero
    genvar gi;

    generate
        for (gi = 0; gi < 32; gi = gi + 1) begin : g_flag
            if (fl_masks[gi]) begin : g_impl
                always @(posedge clk_i or posedge rst_i) begin
                    if (rst_i) begin
                        flag_r[gi] <= 1'b0;
                    end else if (set_vec[gi]) begin
                        flag_r[gi] <= 1'b1;
                    end else if (fl_wr[gi / 8]) begin
                        flag_r[gi] <= avs_writedata_i[gi % 8];
                    end
                end
            end else begin : g_none
                // spare bit, pinned at zero
                always @(posedge clk_i or posedge rst_i) begin
                    if (rst_i) begin
                        flag_r[gi] <= 1'b0;
                    end else begin
                        flag_r[gi] <= 1'b0;
                    end
                end
            end
        end
    endgenerate

    // ------------------------------------------------------------
    // enable registers
    // ------------------------------------------------------------
    // one byte per register, masked to the implemented bits
    genvar gj;

    generate
        for (gj = 0; gj < 8; gj = gj + 1) begin : g_en
            always @(posedge clk_i or posedge rst_i) begin
                if (rst_i) begin
                    en_r[gj*8 +: 8] <= `PIF_EN_RST;
                end else if (en_wr[gj]) begin
                    // the mask drops spare bits
                    en_r[gj*8 +: 8] <= avs_writedata_i[7:0] &
                                       en_masks[gj*8 +: 8];
                end
            end
        end
    endgenerate

    // ------------------------------------------------------------
    // priority and global control
    // ------------------------------------------------------------
    // only the first group sources carry priority bits here
    always @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            pri0_r <= `PIF_PRI0_RST;
            gctl_r <= `PIF_GCTL_RST;
        end else begin
            // spare priority bits stay zero
            if (pri0_wr) begin
                pri0_r <= avs_writedata_i[7:0] & `PIF_GRP0_MASK;
            end

            if (gctl_wr) begin
                gctl_r <= {7'h00, avs_writedata_i[`PIF_GCTL_PEN]};
            end
        end
    end

    // ------------------------------------------------------------
    // request gating
    // ------------------------------------------------------------
    // first group bypasses the global enable; only its own
    // enables and priority bits steer it
    assign grp0_act = first_request_group_i & en_r[7:0] & `PIF_GRP0_MASK;

    // a set priority bit picks the high line
    assign irq_high_nxt = |(grp0_act & pri0_r);
    assign irq_low_nxt  = |(grp0_act & ~pri0_r);

    // remaining groups need flag, enable and global enable
    assign periph_act = |(group1_flags_i & en_r[15:8])  |
                        |(group2_flags_i & en_r[23:16]) |
                        |(group3_flags_i & en_r[31:24]) |
                        |(flag_r & en_r[63:32]);

    // the global enable gates only these groups
    assign irq_periph_nxt = periph_act & gctl_r[`PIF_GCTL_PEN];

    // registered so the cpu sees a glitch-free level
    always @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            irq_high_r   <= 1'b0;
            irq_low_r    <= 1'b0;
            irq_periph_r <= 1'b0;
        end else begin
            irq_high_r   <= irq_high_nxt;
            irq_low_r    <= irq_low_nxt;
            irq_periph_r <= irq_periph_nxt;
        end
    end

    // outputs straight from the request flops
    assign irq_high_o   = irq_high_r;
    assign irq_low_o    = irq_low_r;
    assign irq_periph_o = irq_periph_r;

endmodule // pif_top

`default_nettype wire

/* File: sim/pif_periph_model.sv */
// event source model standing for the timers, capture units,
// memory scan, crc, nvm and waveform generator.
// assumes bench requests change just after a rising edge.
`default_nettype none
module pif_periph_model (
    input  wire logic        clk_i,  // system clock
    input  wire logic        rst_i,  // async reset, high
    input  wire logic [16:0] fire_i, // one request bit per source
    output var  logic [16:0] ev_o    // one-cycle event pulses
);
    timeunit 1ns;
    timeprecision 1ns;
    // ----------------------------------------------------------
    // pulse generation
    // ----------------------------------------------------------
    // one edge late, as a peripheral flags on the edge after its event
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            ev_o <= 17'h0;
        end else begin
            ev_o <= fire_i;
        end
    end
endmodule // pif_periph_model
`default_nettype wire

/* File: sim/pif_asserts.sv */
// port-level checker for the peripheral interrupt block.
// assumes it is bound to pif_top and sees only its ports.
`default_nettype none
module pif_asserts (
    input wire logic        clk_i,                 // system clock
    input wire logic        rst_i,                 // async reset
    input wire logic        avs_read_i,            // read strobe
    input wire logic        avs_write_i,           // write strobe
    input wire logic [31:0] avs_readdata_o,        // read data
    input wire logic        avs_waitrequest_o,     // stall
    input wire logic [7:0]  first_request_group_i, // first group
    input wire logic [7:0]  group1_flags_i,        // group 1 levels
    input wire logic        irq_high_o,            // high request
    input wire logic        irq_low_o,             // low request
    input wire logic        irq_periph_o           // gated request
);
    timeunit 1ns;
    timeprecision 1ns;
    // ----------------------------------------------------------
    // properties, all on the system clock
    // ----------------------------------------------------------
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);
    property p_wr_nowait; avs_write_i |-> !avs_waitrequest_o; endproperty
    a_wr_nowait: assert property (p_wr_nowait) else $error("write stalled");
    property p_rd_wait; $rose(avs_read_i) |-> avs_waitrequest_o ##1 !avs_waitrequest_o; endproperty
    a_rd_wait: assert property (p_rd_wait) else $error("read wait wrong");
    property p_rd_bits; avs_read_i && !avs_waitrequest_o |-> avs_readdata_o[31:8] == 24'h0; endproperty
    a_rd_bits: assert property (p_rd_bits) else $error("upper read bits set");
    property p_rd_hold; !avs_read_i |=> $stable(avs_readdata_o); endproperty
    a_rd_hold: assert property (p_rd_hold) else $error("read data moved");
    // a first-group request needs a live source one edge before
    property p_grp_cause; irq_high_o || irq_low_o |-> ($past(first_request_group_i) & 8'h37) != 8'h0; endproperty
    a_grp_cause: assert property (p_grp_cause) else $error("first group request without source");
    property p_quiet; (first_request_group_i & 8'h37) == 8'h0 |=> !irq_high_o && !irq_low_o; endproperty
    a_quiet: assert property (p_quiet) else $error("first group request while idle");
    // priority level only moves with its inputs or a write
    property p_lvl_hold; ($stable(first_request_group_i) && !avs_write_i) [*2] |=> $stable({irq_high_o, irq_low_o});
    endproperty
    a_lvl_hold: assert property (p_lvl_hold) else $error("priority level moved");
    // flags are sticky: a drop needs a write or a falling level
    property p_periph_hold; $fell(irq_periph_o) |-> $past(avs_write_i, 2) || $past(group1_flags_i, 2) != 8'h0;
    endproperty
    a_periph_hold: assert property (p_periph_hold) else $error("peripheral request dropped");
endmodule // pif_asserts
`default_nettype wire

/* File: sim/testbench.sv */
// self-checking bench for the peripheral interrupt flag block.
// assumes pif_top, pif_asserts and pif_periph_model are compiled.
`include "pif_regs.vh"
`default_nettype none
module testbench;
    timeunit 1ns;
    timeprecision 1ns;
    logic        clk_i = 1'b0;                 // 20 mhz clock
    logic        rst_i = 1'b1;                 // async reset
    logic [13:0] avs_address_i = 14'h0;        // byte address
    logic        avs_read_i = 1'b0;            // read strobe
    logic        avs_write_i = 1'b0;           // write strobe
    logic [31:0] avs_writedata_i = 32'h0;      // write data
    logic [3:0]  be = 4'hf;                    // all lanes on
    logic [31:0] avs_readdata_o;               // read data
    logic        avs_waitrequest_o;            // stall
    logic [16:0] fire = 17'h0;                 // model requests
    logic [16:0] ev;                           // model pulses
    logic [1:0]  cc_mode = 2'h0;               // unit modes
    logic [7:0]  first_request_group_i = 8'h0; // first group
    logic [7:0]  group1_flags_i = 8'h0;        // group 1 levels
    logic [7:0]  group2_flags_i = 8'h0;        // group 2 levels
    logic [7:0]  group3_flags_i = 8'h0;        // unused here
    logic        irq_high_o;                   // high request
    logic        irq_low_o;                    // low request
    logic        irq_periph_o;                 // gated request
    int          n_mismatch = 0;               // failures
    int          n_compared = 0;               // comparisons
    int          cyc = 0;                      // timeout count
    pif_periph_model u_model (.clk_i, .rst_i, .fire_i(fire), .ev_o(ev));
    pif_top DUT (
        .clk_i, .rst_i, .avs_address_i, .avs_read_i, .avs_write_i, .avs_writedata_i,
        .avs_byteenable_i(be), .avs_readdata_o, .avs_waitrequest_o,
        .timer1_overflow_i(ev[0]), .timer2_match_i(ev[1]), .timer3_overflow_i(ev[2]),
        .timer4_match_i(ev[3]), .timer5_overflow_i(ev[4]), .timer6_match_i(ev[5]),
        .timer1_gate_i(ev[6]), .timer3_gate_i(ev[7]), .timer5_gate_i(ev[8]),
        .capcomp1_capture_i(ev[9]), .capcomp1_match_i(ev[10]), .capcomp1_mode_i(cc_mode),
        .capcomp2_capture_i(ev[11]), .capcomp2_match_i(ev[12]), .capcomp2_mode_i(cc_mode),
        .memory_scan_event_i(ev[13]), .checksum_event_i(ev[14]), .nonvolatile_event_i(ev[15]),
        .waveform_gen_event_i(ev[16]), .first_request_group_i, .group1_flags_i,
        .group2_flags_i, .group3_flags_i, .irq_high_o, .irq_low_o, .irq_periph_o
    );
    // ----------------------------------------------------------
    // clock and hang guard
    // ----------------------------------------------------------
    initial begin
        forever #25 clk_i = ~clk_i;
    end
    always @(posedge clk_i) begin
        cyc <= cyc + 1;
        if (cyc == 5000) begin
            n_mismatch = n_mismatch + 1;
            conclude();
        end
    end
    // ----------------------------------------------------------
    // shared tasks
    // ----------------------------------------------------------
    task automatic conclude;
        $display("mismatches %0d compared %0d", n_mismatch, n_compared);
        if (n_mismatch == 0 && n_compared > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            n_mismatch++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // one transfer, then an idle edge so strobes never toggle twice at once
    task automatic bus(input logic w, input logic [11:0] ix, input logic [7:0] d, output logic [31:0] q);
        avs_address_i <= {ix, 2'b00};
        avs_writedata_i <= {24'h0, d};
        avs_write_i <= w;
        avs_read_i <= !w;
        do begin
            @(posedge clk_i);
        end while (avs_waitrequest_o !== 1'b0);
        q = avs_readdata_o;
        avs_write_i <= 1'b0;
        avs_read_i <= 1'b0;
        @(posedge clk_i);
    endtask
    task automatic wr(input logic [11:0] ix, input logic [7:0] d);
        logic [31:0] q;
        bus(1'b1, ix, d, q);
    endtask
    task automatic rd(input logic [11:0] ix, input logic [7:0] e);
        logic [31:0] q;
        bus(1'b0, ix, 8'h00, q);
        chk(q, {24'h0, e});
    endtask
    task automatic pulse(input logic [16:0] v);
        fire <= v;
        @(posedge clk_i);
        fire <= 17'h0;
        @(posedge clk_i);
    endtask
    // request outputs settle one edge after their cause
    task automatic ck_irq(input logic [2:0] e);
        @(posedge clk_i);
        @(negedge clk_i);
        chk({29'h0, irq_high_o, irq_low_o, irq_periph_o}, {29'h0, e});
        @(posedge clk_i);
    endtask
    function automatic logic [11:0] fidx(input int i);
        return (i < 6) ? `PIF_IDX_FL4 : (i < 9) ? `PIF_IDX_FL5 : (i < 13) ? `PIF_IDX_FL6 : `PIF_IDX_FL7;
    endfunction
    // ----------------------------------------------------------
    // scenarios
    // ----------------------------------------------------------
    task automatic t_reset;
        for (int i = 0; i < 4; i++) begin
            rd(`PIF_IDX_EN0 + 12'(i), 8'h00);
            rd(`PIF_IDX_FL4 + 12'(i), 8'h00);
        end
        rd(`PIF_IDX_PRI0, 8'h31);
        wr(12'h123, 8'hff);
        rd(12'h123, 8'h00);
        be <= 4'he;
        wr(`PIF_IDX_EN1, 8'hff);
        be <= 4'hf;
        rd(`PIF_IDX_EN1, 8'h00);
    endtask
    task automatic t_masks;
        logic [7:0] m [4] = '{8'h37, 8'hc3, 8'hc3, 8'hff};
        for (int i = 0; i < 4; i++) begin
            wr(`PIF_IDX_EN0 + 12'(i), 8'hff);
            rd(`PIF_IDX_EN0 + 12'(i), m[i]);
            wr(`PIF_IDX_EN0 + 12'(i), 8'h00);
        end
    endtask
    task automatic t_flags;
        logic [7:0] fb [17] = '{8'h01, 8'h02, 8'h04, 8'h08, 8'h10, 8'h20, 8'h01, 8'h02, 8'h04,
                                8'h01, 8'h01, 8'h02, 8'h02, 8'h80, 8'h40, 8'h20, 8'h01};
        for (int i = 0; i < 17; i++) begin
            cc_mode <= (i == 10 || i == 12) ? `PIF_CC_COMPARE : `PIF_CC_CAPTURE;
            pulse(17'h1 << i);
            rd(fidx(i), fb[i]);
            rd(fidx(i), fb[i]);
            wr(fidx(i), 8'h00);
            rd(fidx(i), 8'h00);
        end
    endtask
    task automatic t_refuse;
        logic [1:0]  md [4] = '{`PIF_CC_PWM, `PIF_CC_COMPARE, `PIF_CC_CAPTURE, 2'h3};
        logic [16:0] evs [4] = '{17'h1e00, 17'h0a00, 17'h1400, 17'h1e00};
        for (int i = 0; i < 4; i++) begin
            cc_mode <= md[i];
            pulse(evs[i]);
            rd(`PIF_IDX_FL6, 8'h00);
        end
    endtask
    task automatic t_periph;
        wr(`PIF_IDX_GCTL, 8'h01);
        wr(`PIF_IDX_EN4, 8'h08);
        pulse(17'h8);
        ck_irq(3'b001);
        wr(`PIF_IDX_EN4, 8'h00);
        ck_irq(3'b000);
        wr(`PIF_IDX_EN4, 8'h08);
        wr(`PIF_IDX_GCTL, 8'h00);
        ck_irq(3'b000);
        wr(`PIF_IDX_FL4, 8'h00);
        group1_flags_i <= 8'h01;
        wr(`PIF_IDX_EN1, 8'h01);
        wr(`PIF_IDX_GCTL, 8'h01);
        ck_irq(3'b001);
        group1_flags_i <= 8'h00;
        ck_irq(3'b000);
        group2_flags_i <= 8'h80;
        wr(`PIF_IDX_EN2, 8'h80);
        ck_irq(3'b001);
        wr(`PIF_IDX_EN2, 8'h00);
        ck_irq(3'b000);
        wr(`PIF_IDX_GCTL, 8'h00);
    endtask
    task automatic t_first;
        first_request_group_i <= 8'h20;
        ck_irq(3'b000);
        wr(`PIF_IDX_EN0, 8'h20);
        ck_irq(3'b100);
        wr(`PIF_IDX_PRI0, 8'h00);
        ck_irq(3'b010);
        first_request_group_i <= 8'h00;
        ck_irq(3'b000);
    endtask
    initial begin
        repeat (8) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        t_reset();
        t_masks();
        t_flags();
        t_refuse();
        t_periph();
        t_first();
        conclude();
    end
endmodule // testbench
bind pif_top pif_asserts u_chk (.clk_i, .rst_i, .avs_read_i, .avs_write_i, .avs_readdata_o, .avs_waitrequest_o,
    .first_request_group_i, .group1_flags_i, .irq_high_o, .irq_low_o, .irq_periph_o);
`default_nettype wire
